// >>> common/sram_host_pkg.sv
// Package for the static RAM host controller: pin groups, timing and states
package sram_host_pkg;
    localparam int ADDR_W      = 10;
    localparam int DATA_W      = 4;
    localparam int WORDS       = 1024;
    localparam int CLK_PERIOD_NS = 50;

    // Standard grade figures in ns
    localparam int ACCESS_NS       = 650;
    localparam int CYCLE_NS        = 650;
    localparam int INHIBIT_SETUP_NS = 150;
    localparam int WRITE_PULSE_NS  = 400;
    localparam int DATA_SETUP_NS   = 400;
    localparam int DATA_HOLD_NS    = 100;
    localparam int ADDR_HOLD_NS    = 50;
    localparam int ADDR_SETUP_NS   = 150;
    localparam int FLOAT_NS        = 150;
    localparam int RECOVERY_NS     = 650;

    // Least times round up to whole cycles, never below one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam int ACCESS_CYC   = cyc_up(ACCESS_NS);
    localparam int INHIBIT_CYC  = cyc_up(INHIBIT_SETUP_NS);
    localparam int ADDR_SU_CYC  = cyc_up(ADDR_SETUP_NS);
    localparam int PULSE_CYC    = cyc_up(WRITE_PULSE_NS > DATA_SETUP_NS ?
                                         WRITE_PULSE_NS : DATA_SETUP_NS);
    localparam int HOLD_CYC     = cyc_up(DATA_HOLD_NS > ADDR_HOLD_NS ?
                                         DATA_HOLD_NS : ADDR_HOLD_NS);
    localparam int FLOAT_CYC    = cyc_up(FLOAT_NS);
    localparam int RECOVERY_CYC = cyc_up(RECOVERY_NS);
    localparam int CNT_W        = 8;

    // Pins driven toward the memory
    typedef struct packed {
        logic [ADDR_W-1:0] word_index;
        logic              select_active_low;
        logic              select_active_high;
        logic              read_not_write;
        logic              output_inhibit;
    } mem_ctrl_t;

    typedef enum logic [6:0] {
        ST_RETAIN  = 7'h01,
        ST_IDLE    = 7'h02,
        ST_RD_WAIT = 7'h04,
        ST_WR_INH  = 7'h08,
        ST_WR_PULSE = 7'h10,
        ST_WR_HOLD = 7'h20,
        ST_FLOAT   = 7'h40
    } host_state_t;
endpackage : sram_host_pkg

// >>> hw/sram_host.sv
// Host controller that drives a 1024 x 4 asynchronous static RAM by its pins
`timescale 1ns/1ns
module sram_host #(
    parameter int ADDR_W = sram_host_pkg::ADDR_W,
    parameter int DATA_W = sram_host_pkg::DATA_W
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire logic              req_valid_in,
    input  wire logic              req_write_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire logic [DATA_W-1:0] req_wdata_in,
    input  wire logic              retain_in,
    output logic                   req_ready_out,
    output logic                   rsp_valid_out,
    output logic [DATA_W-1:0]      rsp_rdata_out,
    output sram_host_pkg::mem_ctrl_t mem_ctrl_out,
    input  wire logic [DATA_W-1:0] shared_data_lines_in,
    output logic [DATA_W-1:0]      shared_data_lines_out,
    output logic                   shared_data_lines_oe_out
);
    ////////////////////////////////////////////////////////////////////////
    // Largest load that the shared down-counter can hold
    localparam int CNT_MAX = (1 << sram_host_pkg::CNT_W) - 1;

    if (ADDR_W != sram_host_pkg::ADDR_W) begin : g_bad_addr_w
        $error("sram_host: address width must match the memory");
    end
    if (DATA_W != sram_host_pkg::DATA_W) begin : g_bad_data_w
        $error("sram_host: data width must match the memory");
    end
    if ((1 << ADDR_W) != sram_host_pkg::WORDS) begin : g_bad_words
        $error("sram_host: address width must reach every word");
    end
    // An overflowing load would silently cut a timing short
    if (sram_host_pkg::ACCESS_CYC > CNT_MAX) begin : g_bad_access
        $error("sram_host: access count exceeds the counter");
    end
    if (sram_host_pkg::INHIBIT_CYC > CNT_MAX) begin : g_bad_inhibit
        $error("sram_host: inhibit count exceeds the counter");
    end
    if (sram_host_pkg::PULSE_CYC > CNT_MAX) begin : g_bad_pulse
        $error("sram_host: pulse count exceeds the counter");
    end
    if (sram_host_pkg::HOLD_CYC > CNT_MAX) begin : g_bad_hold
        $error("sram_host: hold count exceeds the counter");
    end
    if (sram_host_pkg::FLOAT_CYC > CNT_MAX) begin : g_bad_float
        $error("sram_host: float count exceeds the counter");
    end
    if (sram_host_pkg::RECOVERY_CYC > CNT_MAX) begin : g_bad_recovery
        $error("sram_host: recovery count exceeds the counter");
    end

    ////////////////////////////////////////////////////////////////////////
    sram_host_pkg::host_state_t          state_r, state_nxt;
    logic [sram_host_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;
    sram_host_pkg::mem_ctrl_t            ctrl_r, ctrl_nxt;
    logic [DATA_W-1:0]                   wdata_r, wdata_nxt;
    logic                                oe_r, oe_nxt;
    logic [DATA_W-1:0]                   rdata_r, rdata_nxt;
    logic                                rvalid_r, rvalid_nxt;

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        ctrl_nxt   = ctrl_r;
        wdata_nxt  = wdata_r;
        oe_nxt     = oe_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        case (state_r)
            sram_host_pkg::ST_RETAIN: begin
                ctrl_nxt.select_active_low  = 1'b1;
                ctrl_nxt.select_active_high = 1'b0;
                oe_nxt                      = 1'b0;
                // Requests wait here; ready stays low through recovery
                // recovery before access
                if (retain_in) begin
                    cnt_nxt = sram_host_pkg::CNT_W'(sram_host_pkg::RECOVERY_CYC);
                end else if (cnt_r == '0) begin
                    state_nxt = sram_host_pkg::ST_IDLE;
                end
            end
            sram_host_pkg::ST_IDLE: begin
                ctrl_nxt.select_active_low = 1'b1;
                ctrl_nxt.read_not_write    = 1'b1;
                ctrl_nxt.output_inhibit    = 1'b1;
                if (retain_in) begin
                    ctrl_nxt.select_active_high = 1'b0;
                    state_nxt = sram_host_pkg::ST_RETAIN;
                end else if (req_valid_in) begin
                    ctrl_nxt.word_index         = req_addr_in;
                    ctrl_nxt.select_active_low  = 1'b0;
                    ctrl_nxt.select_active_high = 1'b1;
                    wdata_nxt                   = req_wdata_in;
                    if (req_write_in) begin
                        cnt_nxt   = sram_host_pkg::CNT_W'(sram_host_pkg::INHIBIT_CYC);
                        state_nxt = sram_host_pkg::ST_WR_INH;
                    end else begin
                        ctrl_nxt.output_inhibit = 1'b0;
                        cnt_nxt   = sram_host_pkg::CNT_W'(sram_host_pkg::ACCESS_CYC);
                        state_nxt = sram_host_pkg::ST_RD_WAIT;
                    end
                end
            end
            sram_host_pkg::ST_RD_WAIT: begin
                if (cnt_r == '0) begin
                    rdata_nxt               = shared_data_lines_in;
                    rvalid_nxt              = 1'b1;
                    ctrl_nxt.output_inhibit = 1'b1;
                    ctrl_nxt.select_active_low = 1'b1;
                    cnt_nxt   = sram_host_pkg::CNT_W'(sram_host_pkg::FLOAT_CYC);
                    state_nxt = sram_host_pkg::ST_FLOAT;
                end
            end
            sram_host_pkg::ST_WR_INH: begin
                if (cnt_r == '0) begin
                    ctrl_nxt.read_not_write = 1'b0;
                    oe_nxt    = 1'b1;
                    cnt_nxt   = sram_host_pkg::CNT_W'(sram_host_pkg::PULSE_CYC);
                    state_nxt = sram_host_pkg::ST_WR_PULSE;
                end
            end
            sram_host_pkg::ST_WR_PULSE: begin
                if (cnt_r == '0) begin
                    // Rising direction ends the write while data still stands
                    ctrl_nxt.read_not_write = 1'b1;
                    cnt_nxt   = sram_host_pkg::CNT_W'(sram_host_pkg::HOLD_CYC);
                    state_nxt = sram_host_pkg::ST_WR_HOLD;
                end
            end
            sram_host_pkg::ST_WR_HOLD: begin
                if (cnt_r == '0) begin
                    oe_nxt                     = 1'b0;
                    ctrl_nxt.select_active_low = 1'b1;
                    rvalid_nxt                 = 1'b1;
                    state_nxt                  = sram_host_pkg::ST_IDLE;
                end
            end
            sram_host_pkg::ST_FLOAT: begin
                if (cnt_r == '0) begin
                    state_nxt = sram_host_pkg::ST_IDLE;
                end
            end
            default: begin
                // A corrupted state code recovers to idle
                state_nxt = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            // Reset leaves the memory deselected and the bus released
            state_r  <= sram_host_pkg::ST_RETAIN;
            cnt_r    <= sram_host_pkg::CNT_W'(sram_host_pkg::RECOVERY_CYC);
            ctrl_r   <= '{word_index: '0, select_active_low: 1'b1,
                          select_active_high: 1'b0, read_not_write: 1'b1,
                          output_inhibit: 1'b1};
            wdata_r  <= '0;
            oe_r     <= 1'b0;
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            ctrl_r   <= ctrl_nxt;
            wdata_r  <= wdata_nxt;
            oe_r     <= oe_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accepting only in idle keeps one access on the pins at a time
    assign req_ready_out            = (state_r == sram_host_pkg::ST_IDLE) && !retain_in;
    // Answer and pins come straight from flip-flops
    assign rsp_valid_out            = rvalid_r;
    assign rsp_rdata_out            = rdata_r;
    assign mem_ctrl_out             = ctrl_r;
    assign shared_data_lines_out    = wdata_r;
    assign shared_data_lines_oe_out = oe_r;
endmodule : sram_host

// >>> verification/sram_async_model.sv
// Behavioural 1024 x 4 static RAM on the far side of the pins
`timescale 1ns/1ns
module sram_async_model (
    input sram_host_pkg::mem_ctrl_t ctrl_in,
    input wire logic [3:0]          bus_in,
    output logic [3:0]              bus_out,
    output logic                    drive_out
);
    logic [3:0] cells [0:1023];
    logic [3:0] wander = 4'h5;
    logic       ready = 1'b0;
    logic       sel;
    time        t0 = 0;
    assign sel = !ctrl_in.select_active_low && ctrl_in.select_active_high;
    // drive only a selected read without inhibit
    assign drive_out = sel && ctrl_in.read_not_write && !ctrl_in.output_inhibit;
    // no inversion; undriven lines wander so stale values never pass
    assign bus_out = (drive_out && ready) ? cells[ctrl_in.word_index] : wander;
    always @(ctrl_in.word_index or sel) t0 = $time;
    // data valid only once the access time has run
    always #5 begin
        wander = wander + 4'h3;
        ready = sel && ($time - t0 >= sram_host_pkg::ACCESS_NS);
    end
    // stored at end of write pulse, kept with no refresh
    always @(posedge ctrl_in.read_not_write) if (sel) cells[ctrl_in.word_index] = bus_in;
endmodule : sram_async_model

// >>> verification/sram_host_checker.sv
// Checker of the host pin timing toward the static RAM
`timescale 1ns/1ns
module sram_host_checker #(
    parameter int DATA_W = sram_host_pkg::DATA_W
) (
    input wire logic              ref_clk_in,
    input wire logic              rst_in,
    input wire logic              req_valid_in,
    input wire logic              req_write_in,
    input wire logic              retain_in,
    input wire logic              req_ready_out,
    input wire logic              rsp_valid_out,
    input sram_host_pkg::mem_ctrl_t mem_ctrl_out,
    input wire logic [DATA_W-1:0] shared_data_lines_out,
    input wire logic              shared_data_lines_oe_out
);
    logic       sel;
    logic [7:0] calm_r;
    logic [7:0] calm_nxt;
    assign sel = !mem_ctrl_out.select_active_low && mem_ctrl_out.select_active_high;
    // Cycles since retention ended; saturates so long idles never wrap
    always_comb calm_nxt = retain_in ? 8'h00 : (calm_r == 8'hff ? calm_r : calm_r + 8'h01);
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) calm_r <= 8'h00;
        else calm_r <= calm_nxt;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    chk_read_latency: assert property (
        req_valid_in && req_ready_out && !req_write_in |-> ##15 rsp_valid_out)
        else $error("read answer late");
    chk_drive_inhibit: assert property (
        shared_data_lines_oe_out |-> mem_ctrl_out.output_inhibit) else $error("drive uninhibited");
    chk_write_driven: assert property (
        !mem_ctrl_out.read_not_write |-> shared_data_lines_oe_out && sel)
        else $error("write without data");
    chk_inhibit_setup: assert property (
        $rose(shared_data_lines_oe_out) |-> $past(mem_ctrl_out.output_inhibit, 3))
        else $error("inhibit setup short");
    chk_addr_hold: assert property (
        $rose(mem_ctrl_out.read_not_write) |=> $stable(mem_ctrl_out.word_index))
        else $error("address moved after write");
    chk_data_hold: assert property (
        shared_data_lines_oe_out && $past(shared_data_lines_oe_out) |->
        $stable(shared_data_lines_out) && $stable(mem_ctrl_out.word_index))
        else $error("write data moved");
    chk_recovery_wait: assert property (
        $rose(sel) |-> calm_r >= sram_host_pkg::RECOVERY_CYC) else $error("recovery short");
    chk_retain_idle: assert property (
        retain_in |-> !req_ready_out) else $error("ready in retention");
    chk_retain_deselect: assert property (
        retain_in && !sel |=> !sel) else $error("selected in retention");
    chk_addr_steady: assert property (
        sel && $past(sel) |-> $stable(mem_ctrl_out.word_index))
        else $error("address moved while enabled");
    chk_write_latency: assert property (
        req_valid_in && req_ready_out && req_write_in |-> ##17 rsp_valid_out)
        else $error("write answer late");
    cov_read: cover property (req_valid_in && req_ready_out && !req_write_in);
    cov_write: cover property (req_valid_in && req_ready_out && req_write_in);
    cov_retain: cover property ($fell(retain_in));
endmodule : sram_host_checker
bind sram_host sram_host_checker #(.DATA_W(DATA_W)) u_chk (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .retain_in(retain_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .mem_ctrl_out(mem_ctrl_out), .shared_data_lines_out(shared_data_lines_out),
    .shared_data_lines_oe_out(shared_data_lines_oe_out));

// >>> verification/tb_top.sv
// Self-checking bench: host controller against the static RAM model
`timescale 1ns/1ns
module tb_top;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, req_write_in = 1'b0;
    logic retain_in = 1'b0, req_ready_out, rsp_valid_out, oe, mdrv;
    logic [9:0] req_addr_in = 10'h000, a;
    logic [3:0] req_wdata_in = 4'h0, rsp_rdata_out, dout, mout, bus, d;
    logic [3:0] shadow [0:1023];
    logic [4:0] notes [$];
    logic [4:0] note;
    sram_host_pkg::mem_ctrl_t ctrl;
    int fails = 0, n_compared = 0;
    always #25 ref_clk_in = ~ref_clk_in;
    assign bus = oe ? dout : mout;
    sram_host DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .retain_in(retain_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .mem_ctrl_out(ctrl), .shared_data_lines_in(bus),
        .shared_data_lines_out(dout), .shared_data_lines_oe_out(oe));
    sram_async_model mem (.ctrl_in(ctrl), .bus_in(bus), .bus_out(mout), .drive_out(mdrv));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Request held until the edge where ready is high; valid stays up for back to back
    task automatic access(input logic w, input logic [9:0] ad, input logic [3:0] dw);
        req_valid_in <= 1'b1;
        req_write_in <= w;
        req_addr_in <= ad;
        req_wdata_in <= dw;
        do @(negedge ref_clk_in); while (req_ready_out !== 1'b1);
        @(posedge ref_clk_in);
        notes.push_back({w, w ? dw : shadow[ad]});
        if (w) shadow[ad] = dw;
    endtask : access
    ////////////////////////////////////////////////////////////////
    always @(negedge ref_clk_in) begin
        if (oe === 1'b1) check("model drive under host", 4'h0, {3'h0, mdrv});
        if (rsp_valid_out === 1'b1) begin
            if (notes.size() == 0) check("unexpected answer", 4'h0, 4'hf);
            else begin
                note = notes.pop_front();
                if (!note[4]) check("read data", note[3:0], rsp_rdata_out);
            end
        end
    end
    initial begin
        #400_000;
        fails++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hc2e2));
        repeat (4) @(posedge ref_clk_in);
        check("reset pins", 4'hb, {ctrl.select_active_low, ctrl.select_active_high,
              ctrl.read_not_write, ctrl.output_inhibit});
        rst_in <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            a = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
            d = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
            access(1'b1, a, d);
            access(1'b0, a, 4'($urandom));
            access(1'b0, a, 4'($urandom));
        end
        access(1'b1, 10'h000, 4'h5);
        access(1'b1, 10'h000, 4'ha);
        access(1'b0, 10'h000, 4'h0);
        req_valid_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        retain_in <= 1'b1;
        fork
            access(1'b0, 10'h3ff, 4'h0);
            begin
                repeat (30) @(posedge ref_clk_in);
                retain_in <= 1'b0;
            end
        join
        req_valid_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        access(1'b0, 10'h000, 4'h0);
        req_valid_in <= 1'b0;
        repeat (40) @(posedge ref_clk_in);
        check("answers left over", 4'h0, 4'(notes.size()));
        end_sim();
    end
endmodule : tb_top
